// >>> pkg/power_gating_pkg.sv
package power_gating_pkg;

    // Register byte addresses
    localparam logic [7:0] DIVCTL_ADDR     = 8'h00;
    localparam logic [7:0] GATE1_ADDR      = 8'h04;
    localparam logic [7:0] GATE2_ADDR      = 8'h08;
    localparam logic [7:0] GATE3_ADDR      = 8'h0C;
    localparam logic [7:0] GATE4_ADDR      = 8'h10;
    localparam logic [7:0] GATE6_ADDR      = 8'h14;
    localparam logic [7:0] GATE7_ADDR      = 8'h18;
    localparam logic [7:0] STATUS_ADDR     = 8'h1C;

    // Divider register fields
    localparam int SLOW_EN_BIT    = 11;
    localparam int RATIO_LSB      = 12;
    localparam int RATIO_MSB      = 14;
    localparam int RET_BIT        = 15;
    localparam logic [2:0] RATIO_RESET = 3'h0;
    localparam logic [15:0] DIVCTL_MASK = 16'hF800;

    // Implemented bits of each gating register
    localparam logic [15:0] GATE1_MASK = 16'hFEFB;
    localparam logic [15:0] GATE2_MASK = 16'h0F0F;
    localparam logic [15:0] GATE3_MASK = 16'h0482;
    localparam logic [15:0] GATE4_MASK = 16'h000C;
    localparam logic [15:0] GATE6_MASK = 16'h0700;
    localparam logic [15:0] GATE7_MASK = 16'h0018;
    localparam logic [15:0] GATE_RESET = 16'h0000;

    // Gated module count: six registers of sixteen bits
    localparam int NUM_GATE_REGS = 6;
    localparam int NUM_MODULES   = 96;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> hw/cpu_slow_divider.sv
`timescale 1ns/1ps
`default_nettype none

// Produces a one-cycle CPU clock enable every 2**ratio system clocks in slow mode, every system clock otherwise
module cpu_slow_divider (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       resetn,
    // Control
    input  wire logic       slow_active,
    input  wire logic [2:0] ratio,
    // Enable out
    output logic            cpu_tick
);

    logic [6:0] count_r;
    logic [6:0] count_nxt;
    logic       tick_nxt;
    logic [6:0] limit;

    // Next count; wraps at the selected ratio
    always_comb begin
        limit     = 7'((8'h01 << ratio) - 8'h01);
        count_nxt = count_r + 7'h01;
        tick_nxt  = 1'b0;
        if (!slow_active || count_r >= limit) begin
            count_nxt = 7'h00;
            tick_nxt  = 1'b1;
        end
    end

    // Register stage; the tick stays aligned to the system clock
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count_r  <= 7'h00;
            cpu_tick <= 1'b1;
        end else begin
            count_r  <= count_nxt;
            cpu_tick <= tick_nxt;
        end
    end

endmodule
`default_nettype wire

// >>> hw/module_gate_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Delays gate bits by one CPU instruction cycle before they act
module module_gate_sync #(
    parameter int WIDTH = 96
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    // Instruction cycle enable
    input  wire logic             cpu_tick,
    // Gate bits in and module enables out
    input  wire logic [WIDTH-1:0] gate_bits,
    input  wire logic [WIDTH-1:0] present,
    output logic      [WIDTH-1:0] module_run
);

    logic [WIDTH-1:0] run_nxt;

    // Update only on an instruction boundary
    always_comb begin
        run_nxt = module_run;
        if (cpu_tick) begin
            run_nxt = ~gate_bits & present;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            module_run <= '0;
        end else begin
            module_run <= run_nxt;
        end
    end

endmodule
`default_nettype wire

// >>> hw/power_gating_ctrl.sv
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Slow mode divides only the CPU enable; peripheral clock enables stay full rate.
// - CPU enable is a pulse on the system clock, so domains stay aligned.
// - Bit 11 of the divider register turns slow mode on.
// - Bits 14:12 choose ratio, eight settings 1:1 to 1:128, reset 1:1.
// - Bit 15 set makes an interrupt clear slow mode; clear ignores interrupts.
// - A set gate bit stops every clock enable of that module.
// - Gated module register writes are blocked and its reads are marked invalid.
// - A module runs only if ungated and present on this variant.
// - All implemented gate bits reset to zero.
// - Gate changes act one instruction cycle after the write.
// - Fourth register: reference clock output bit 3, charge-time bit 2.
// - Seventh register: bit 4 gates all DMA, bit 3 trigger generator.
// - Unimplemented gate bits read as zero.
module power_gating_ctrl #(
    parameter logic [95:0] PRESENT = {96{1'b1}}
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         resetn,
    // AXI4-Lite write address
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // Interrupt event from the interrupt controller
    input  wire logic         irq_event,
    // Peripheral register access checks
    input  wire logic [6:0]   periph_sel,
    input  wire logic         periph_wr,
    output logic              periph_wr_allow,
    output logic              periph_rd_valid,
    // Clock enables
    output logic              cpu_clk_en,
    output logic              periph_clk_en,
    output logic [95:0]       module_clk_en,
    output logic [95:0]       module_run
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [15:0] divctl_r;
    logic [15:0] divctl_nxt;
    logic [15:0] gate_r   [power_gating_pkg::NUM_GATE_REGS];
    logic [15:0] gate_nxt [power_gating_pkg::NUM_GATE_REGS];
    logic [15:0] gate_mask [power_gating_pkg::NUM_GATE_REGS];
    logic [95:0] gate_flat;
    logic [95:0] run_w;
    logic        cpu_tick;

    // Bus state
    logic        aw_held_r, aw_held_nxt;
    logic        w_held_r, w_held_nxt;
    logic [7:0]  awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic [3:0]  wstrb_r, wstrb_nxt;
    logic        bvalid_nxt, rvalid_nxt;
    logic [1:0]  bresp_nxt, rresp_nxt;
    logic [31:0] rdata_nxt;
    logic        do_write;
    logic        hit_w, hit_r;
    logic [15:0] rd_val;

    // Output stage state
    logic        wr_allow_nxt, rd_valid_nxt;

    // Implemented bit masks per gating register
    always_comb begin
        gate_mask[0] = power_gating_pkg::GATE1_MASK;
        gate_mask[1] = power_gating_pkg::GATE2_MASK;
        gate_mask[2] = power_gating_pkg::GATE3_MASK;
        gate_mask[3] = power_gating_pkg::GATE4_MASK;
        gate_mask[4] = power_gating_pkg::GATE6_MASK;
        gate_mask[5] = power_gating_pkg::GATE7_MASK;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data accepted in either order
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt  = w_held_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = s_axi_bvalid;
        bresp_nxt   = s_axi_bresp;
        do_write    = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_held_r && w_held_r && !s_axi_bvalid) begin
            do_write    = 1'b1;
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = hit_w ? power_gating_pkg::RESP_OKAY : power_gating_pkg::RESP_SLVERR;
        end
    end

    // Address hit for the held write address
    always_comb begin
        unique case (awaddr_r)
            power_gating_pkg::DIVCTL_ADDR, power_gating_pkg::GATE1_ADDR,
            power_gating_pkg::GATE2_ADDR,  power_gating_pkg::GATE3_ADDR,
            power_gating_pkg::GATE4_ADDR,  power_gating_pkg::GATE6_ADDR,
            power_gating_pkg::GATE7_ADDR,  power_gating_pkg::STATUS_ADDR: hit_w = 1'b1;
            default: hit_w = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register updates; low two byte lanes carry the 16-bit registers
    always_comb begin
        logic [15:0] wmask;
        wmask      = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
        divctl_nxt = divctl_r;
        for (int i = 0; i < power_gating_pkg::NUM_GATE_REGS; i++) begin
            gate_nxt[i] = gate_r[i];
        end
        if (do_write) begin
            if (awaddr_r == power_gating_pkg::DIVCTL_ADDR) begin
                // Only slow enable, ratio and return bits exist
                divctl_nxt = ((divctl_r & ~wmask) | (wdata_r[15:0] & wmask))
                             & power_gating_pkg::DIVCTL_MASK;
            end
            for (int i = 0; i < power_gating_pkg::NUM_GATE_REGS; i++) begin
                if (awaddr_r == 8'(power_gating_pkg::GATE1_ADDR + 8'(4 * i))) begin
                    gate_nxt[i] = ((gate_r[i] & ~wmask) | (wdata_r[15:0] & wmask))
                                  & gate_mask[i];
                end
            end
        end
        // Interrupt return wins over a write in the same cycle
        if (irq_event && divctl_r[power_gating_pkg::RET_BIT]) begin
            divctl_nxt[power_gating_pkg::SLOW_EN_BIT] = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            divctl_r  <= {1'b0, power_gating_pkg::RATIO_RESET, 12'h000}; // Ratio field resets to 1:1
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            for (int i = 0; i < power_gating_pkg::NUM_GATE_REGS; i++) begin
                gate_r[i] <= power_gating_pkg::GATE_RESET;
            end
        end else begin
            divctl_r  <= divctl_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            for (int i = 0; i < power_gating_pkg::NUM_GATE_REGS; i++) begin
                gate_r[i] <= gate_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle from address to data
    always_comb begin
        rd_val = 16'h0000;
        hit_r  = 1'b1;
        unique case (s_axi_araddr)
            power_gating_pkg::DIVCTL_ADDR: rd_val = divctl_r;
            power_gating_pkg::GATE1_ADDR:  rd_val = gate_r[0];
            power_gating_pkg::GATE2_ADDR:  rd_val = gate_r[1];
            power_gating_pkg::GATE3_ADDR:  rd_val = gate_r[2];
            power_gating_pkg::GATE4_ADDR:  rd_val = gate_r[3];
            power_gating_pkg::GATE6_ADDR:  rd_val = gate_r[4];
            power_gating_pkg::GATE7_ADDR:  rd_val = gate_r[5];
            // Live state: slow mode running, CPU tick phase
            power_gating_pkg::STATUS_ADDR: rd_val = {14'h0000, cpu_tick, divctl_r[power_gating_pkg::SLOW_EN_BIT]};
            default:                       hit_r  = 1'b0;
        endcase
        rvalid_nxt = s_axi_rvalid;
        rdata_nxt  = s_axi_rdata;
        rresp_nxt  = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = {16'h0000, rd_val};
            rresp_nxt  = hit_r ? power_gating_pkg::RESP_OKAY : power_gating_pkg::RESP_SLVERR;
        end
    end

    // Bus outputs all registered
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            // Ready stays low after each handshake until the held beat is consumed, so no second beat sneaks in
            s_axi_awready <= !aw_held_nxt && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held_nxt && !(s_axi_wvalid && s_axi_wready);
            s_axi_bvalid  <= bvalid_nxt;
            s_axi_bresp   <= bresp_nxt;
            s_axi_arready <= !rvalid_nxt && !(s_axi_arvalid && s_axi_arready);
            s_axi_rvalid  <= rvalid_nxt;
            s_axi_rdata   <= rdata_nxt;
            s_axi_rresp   <= rresp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CPU slow clock enable
    cpu_slow_divider u_div (
        .mclk        (mclk),
        .resetn      (resetn),
        .slow_active (divctl_r[power_gating_pkg::SLOW_EN_BIT]),
        .ratio       (divctl_r[power_gating_pkg::RATIO_MSB:power_gating_pkg::RATIO_LSB]),
        .cpu_tick    (cpu_tick)
    );

    // Flatten gate registers for the per-module stage
    always_comb begin
        for (int i = 0; i < power_gating_pkg::NUM_GATE_REGS; i++) begin
            gate_flat[16*i +: 16] = gate_r[i];
        end
    end

    // Gate changes land on the next instruction boundary
    module_gate_sync #(
        .WIDTH (power_gating_pkg::NUM_MODULES)
    ) u_sync (
        .mclk       (mclk),
        .resetn     (resetn),
        .cpu_tick   (cpu_tick),
        .gate_bits  (gate_flat),
        .present    (PRESENT & {gate_mask[5], gate_mask[4], gate_mask[3],
                                gate_mask[2], gate_mask[1], gate_mask[0]}),
        .module_run (run_w)
    );

    // Peripheral access check and clock enables
    always_comb begin
        wr_allow_nxt = run_w[{periph_sel[6:4] == 3'h0 ? 3'h0 : periph_sel[6:4], periph_sel[3:0]}];
        rd_valid_nxt = wr_allow_nxt;
        wr_allow_nxt = wr_allow_nxt & periph_wr;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cpu_clk_en      <= 1'b0;
            periph_clk_en   <= 1'b0;
            module_clk_en   <= '0;
            module_run      <= '0;
            periph_wr_allow <= 1'b0;
            periph_rd_valid <= 1'b0;
        end else begin
            cpu_clk_en      <= cpu_tick;
            periph_clk_en   <= 1'b1;
            module_clk_en   <= run_w;
            module_run      <= run_w;
            periph_wr_allow <= wr_allow_nxt;
            periph_rd_valid <= rd_valid_nxt;
        end
    end

endmodule
`default_nettype wire

// >>> testbench/power_gating_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none

module power_gating_ctrl_props (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        resetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Access checks and enables
    input wire logic [6:0]  periph_sel,
    input wire logic        periph_wr_allow,
    input wire logic        periph_rd_valid,
    input wire logic        cpu_clk_en,
    input wire logic        periph_clk_en,
    input wire logic [95:0] module_clk_en,
    input wire logic [95:0] module_run
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    ////////////////////////////////////////////////////////////////////////////
    // Selection one cycle back; access flags and run state share that register stage
    logic [6:0] sel_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sel_q <= 7'h00;
        end else begin
            sel_q <= periph_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_periph_rate: assert property ($past(resetn, 2) |-> periph_clk_en)
        else $error("peripheral clock enable dropped");
    chk_clk_follows: assert property ($past(resetn, 2) |-> module_clk_en == module_run)
        else $error("module clock enable not following run state");
    chk_gated_access: assert property (!module_run[sel_q] |-> !periph_wr_allow && !periph_rd_valid)
        else $error("access allowed to stopped module");
    chk_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");

    // Main scenarios
    cover property (s_axi_bvalid && s_axi_bready);
    cover property ($fell(cpu_clk_en));
    cover property (periph_wr_allow);
endmodule

`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [95:0] PRES = {{95{1'b1}}, 1'b0}; // ADC absent on this variant
    localparam logic [1:0]  OK_R = power_gating_pkg::RESP_OKAY;
    logic        mclk, resetn, irq_event, periph_wr;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [6:0]  periph_sel;
    logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
    logic        periph_wr_allow, periph_rd_valid, cpu_clk_en, periph_clk_en;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [95:0] module_clk_en, module_run;
    logic [7:0]  gaddr [6];
    logic [15:0] gmask [6];
    int          fail_count, checks_done;

    power_gating_ctrl #(.PRESENT(PRES)) power_gating_ctrl_inst (.mclk, .resetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_event, .periph_sel, .periph_wr,
        .periph_wr_allow, .periph_rd_valid, .cpu_clk_en, .periph_clk_en, .module_clk_en, .module_run);

    ////////////////////////////////////////////////////////////////////////////
    // Reporting
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic hang();
        fail_count++;
        $display("[FAIL] %0t wait limit reached", $time);
        finish_test();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycles; response ready goes up with the request and stays until the answer
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!s_axi_bvalid) begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (++n > 50) hang();
        end
        check(32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                          input logic [31:0] m = 32'hFFFFFFFF);
        int n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!s_axi_rvalid) begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (++n > 50) hang();
        end
        check(s_axi_rdata & m, e & m);
        check(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
    endtask

    // Bounded wait for a run pattern, then the clock enables two cycles later
    task automatic wait_run(input int b, input logic [15:0] m, input logic [15:0] e);
        int n = 0;
        while ((module_run[b+:16] & m) !== e) begin
            @(posedge mclk);
            if (++n > 300) hang();
        end
        repeat (2) @(posedge mclk);
        check(32'(module_clk_en[b+:16] & m), 32'(e));
    endtask

    // Cycles between two CPU enables
    task automatic gap(output int g);
        int n = 0;
        do begin
            @(posedge mclk);
            if (++n > 300) hang();
        end while (!cpu_clk_en);
        g = 0;
        do begin
            @(posedge mclk);
            if (++g > 300) hang();
        end while (!cpu_clk_en);
    endtask

    task automatic irq_pulse();
        @(posedge mclk);
        irq_event <= 1'b1;
        @(posedge mclk);
        irq_event <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        for (int i = 0; i < 6; i++) axi_rd(gaddr[i], 32'h0, OK_R);
        axi_rd(power_gating_pkg::DIVCTL_ADDR, 32'h0, OK_R);
        check(32'(cpu_clk_en), 32'h1);
        for (int i = 0; i < 6; i++) wait_run(i * 16, gmask[i], gmask[i] & PRES[i*16+:16]);
    endtask

    // Absent module bit is left out of the read comparison
    task automatic t_gates();
        for (int i = 0; i < 6; i++) begin
            axi_wr(gaddr[i], 32'hFFFFFFFF, OK_R);
            axi_rd(gaddr[i], 32'(gmask[i]), OK_R, {31'h7FFFFFFF, i != 0});
            wait_run(i * 16, gmask[i], 16'h0000);
            axi_wr(gaddr[i], 32'h0, OK_R);
            wait_run(i * 16, gmask[i], gmask[i] & PRES[i*16+:16]);
        end
    endtask

    task automatic t_ratio();
        int g;
        for (int r = 0; r < 8; r++) begin
            axi_wr(power_gating_pkg::DIVCTL_ADDR, (32'(r) << 12) | 32'h0800, OK_R);
            gap(g);
            gap(g);
            check(32'(g), 32'(1 << r));
            check(32'(periph_clk_en), 32'h1);
        end
        axi_wr(power_gating_pkg::DIVCTL_ADDR, 32'h7000, OK_R);
        gap(g);
        check(32'(g), 32'h1);
    endtask

    task automatic t_irq();
        int g;
        axi_wr(power_gating_pkg::DIVCTL_ADDR, 32'hB800, OK_R);
        irq_pulse();
        axi_rd(power_gating_pkg::DIVCTL_ADDR, 32'hB000, OK_R);
        axi_rd(power_gating_pkg::STATUS_ADDR, 32'h0, OK_R, 32'hFFFFFFFD);
        gap(g);
        check(32'(g), 32'h1);
        axi_wr(power_gating_pkg::DIVCTL_ADDR, 32'h3800, OK_R);
        irq_pulse();
        axi_rd(power_gating_pkg::DIVCTL_ADDR, 32'h3800, OK_R);
        axi_rd(power_gating_pkg::STATUS_ADDR, 32'h1, OK_R, 32'hFFFFFFFD);
        gap(g);
        gap(g);
        check(32'(g), 32'h8);
    endtask

    // Runs in slow mode, so gate changes wait for CPU enables
    task automatic t_access();
        @(posedge mclk);
        periph_sel <= 7'd11;
        periph_wr <= 1'b1;
        repeat (3) @(posedge mclk);
        check(32'({periph_wr_allow, periph_rd_valid}), 32'h3);
        axi_wr(power_gating_pkg::GATE1_ADDR, 32'h0800, OK_R);
        wait_run(0, 16'h0800, 16'h0000);
        check(32'({periph_wr_allow, periph_rd_valid}), 32'h0);
        @(posedge mclk);
        periph_sel <= 7'd0;
        repeat (3) @(posedge mclk);
        check(32'({periph_wr_allow, periph_rd_valid}), 32'h0);
        axi_wr(power_gating_pkg::GATE1_ADDR, 32'h0, OK_R);
        periph_sel <= 7'd11;
        wait_run(0, 16'h0800, 16'h0800);
        check(32'({periph_wr_allow, periph_rd_valid}), 32'h3);
    endtask

    task automatic t_bad();
        axi_wr(8'h20, 32'hFFFF, power_gating_pkg::RESP_SLVERR);
        axi_rd(8'h20, 32'h0, power_gating_pkg::RESP_SLVERR);
        axi_rd(power_gating_pkg::GATE1_ADDR, 32'h0, OK_R);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        {resetn, irq_event, periph_wr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, periph_sel} = '0;
        s_axi_wstrb = 4'hF;
        gaddr = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
        gmask = '{power_gating_pkg::GATE1_MASK, power_gating_pkg::GATE2_MASK, power_gating_pkg::GATE3_MASK,
                  power_gating_pkg::GATE4_MASK, power_gating_pkg::GATE6_MASK, power_gating_pkg::GATE7_MASK};
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_gates();
        t_ratio();
        t_irq();
        t_access();
        t_bad();
        finish_test();
    end
endmodule

bind power_gating_ctrl power_gating_ctrl_props power_gating_ctrl_props_inst (.mclk, .resetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_sel,
    .periph_wr_allow, .periph_rd_valid, .cpu_clk_en, .periph_clk_en, .module_clk_en, .module_run);

`default_nettype wire
